// ### asc_pkg.sv
// shared constants for the sample step control block
package asc_pkg;

	// register bus
	localparam int          ADDR_W      = 12;
	localparam int          DATA_W      = 32;
	localparam logic [11:0] OFS_CTRL    = 12'h000;
	localparam logic [11:0] OFS_RAW     = 12'h004;
	localparam logic [11:0] OFS_MASK    = 12'h008;
	localparam logic [11:0] OFS_CLR     = 12'h00c;
	localparam logic [11:0] OFS_MUX     = 12'h040;
	localparam logic [11:0] OFS_STEP    = 12'h044;

	// sequencer control register bits
	localparam int          CTRL_EN     = 0;
	localparam int          CTRL_START  = 1;
	localparam int          CTRL_BUSY   = 2;

	// per-slot nibble of the step control word
	localparam int          NUM_SLOTS   = 8;
	localparam int          FIELD_W     = 4;
	localparam int          F_TEMP      = 3;
	localparam int          F_IRQ       = 2;
	localparam int          F_END       = 1;
	localparam int          F_DIFF      = 0;
	localparam int          SLOT_SIX    = 5; // sixth sample, counted from zero
	localparam int          SIX_TEMP    = 23;

	// per-slot input select field
	localparam int          MUX_W       = 3;
	localparam int          CH_W        = 4;
	localparam logic [31:0] MUX_MASK    = 32'h7777_7777;
	localparam logic [31:0] STEP_RST    = 32'h0000_0000;
	localparam logic [31:0] MUX_RST     = 32'h0000_0000;

	// interrupt status bits
	localparam int          IRQ_W       = 3;
	localparam int          ST_RAW      = 0;
	localparam int          ST_DONE     = 1;
	localparam int          ST_NOEND    = 2;
	localparam logic [2:0]  IRQ_RST     = 3'h0;

	typedef enum logic [1:0] {
		ASC_IDLE = 2'b00,
		ASC_REQ  = 2'b01,
		ASC_WAIT = 2'b10
	} asc_state_t;

endpackage

// ### asc_irq_stat.sv
// sticky event status with enable gating onto one interrupt
`timescale 1ns/1ps
module asc_irq_stat #(
	parameter int W = asc_pkg::IRQ_W
) (
	input  wire logic         core_clk_i, // system clock
	input  wire logic         rst_b_i,    // async reset, active low
	input  wire logic [W-1:0] set_i,      // event pulses
	input  wire logic         clr_we_i,   // clear register written
	input  wire logic [W-1:0] clr_i,      // bits to clear
	input  wire logic [W-1:0] en_i,       // enable (mask) bits
	output logic      [W-1:0] status_o,   // sticky status
	output logic              irq_o       // level interrupt
);

	logic [W-1:0] status_q;

	// set wins over a clear in the same cycle
	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			status_q <= asc_pkg::IRQ_RST;
		else
			status_q <= (status_q & ~(clr_we_i ? clr_i : '0)) | set_i;
	end

	assign status_o = status_q;
	assign irq_o    = |(status_q & en_i);

endmodule

// ### asc_step_ctrl.sv
// step control for the eight-slot sample sequencer
//
// Behaviour
// - a slot with its temperature bit set converts the sensor, otherwise its selected input.
// - a slot with its interrupt bit set raises the raw flag when its conversion ends.
// - the raw flag reaches the interrupt output only while its mask bit is set.
// - several slots of one sequence may each raise the raw flag.
// - the slot with its end marker set is the last of the sequence, at any position.
// - no slot after the first end marker is ever requested.
// - a one-slot sequencer has its first end marker forced to one.
// - a slot with its differential bit set samples a differential pair; here a slot with its temperature bit also set converts the sensor instead.
// - each slot owns a nibble: temperature, interrupt, end, differential; slot six is 23:20.
// - all per-slot control bits are read/write and clear to zero on reset, except the forced end marker of a one-slot sequencer.
// - each slot has a three-bit input select in the companion register.
// - the step control word is 32 bits wide and covers eight slots.
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module asc_step_ctrl #(
	parameter int NUM_SLOTS = asc_pkg::NUM_SLOTS
) (
	input  wire logic                       core_clk_i,   // system clock
	input  wire logic                       rst_b_i,      // async reset, active low
	input  wire logic [asc_pkg::ADDR_W-1:0] addr_i,       // register byte address
	input  wire logic [asc_pkg::DATA_W-1:0] wdata_i,      // write data
	input  wire logic                       wr_i,         // write strobe
	input  wire logic                       rd_i,         // read strobe
	output logic      [asc_pkg::DATA_W-1:0] rdata_o,      // read data, next cycle
	output logic                            conv_req_o,   // conversion request pulse
	output logic                            conv_temp_o,  // convert temperature sensor
	output logic                            conv_diff_o,  // differential sampling
	output logic      [asc_pkg::CH_W-1:0]   conv_pos_o,   // positive / single input
	output logic      [asc_pkg::CH_W-1:0]   conv_neg_o,   // negative leg input
	input  wire logic                       conv_done_i,  // conversion finished pulse
	output logic                            busy_o,       // sequence in progress
	output logic                            irq_o         // level interrupt
);

	localparam int SW = (NUM_SLOTS > 1) ? $clog2(NUM_SLOTS) : 1;
	localparam logic [SW-1:0] LAST = SW'(NUM_SLOTS - 1);
	localparam int FW = asc_pkg::FIELD_W;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [FW-1:0] slot_bits(input logic [31:0] c, input logic [SW-1:0] s);
		slot_bits = c[int'(s) * FW +: FW];
	endfunction

	function automatic logic [asc_pkg::MUX_W-1:0] slot_mux(input logic [31:0] m,
		input logic [SW-1:0] s);
		slot_mux = m[int'(s) * FW +: asc_pkg::MUX_W];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// registers

	logic [31:0]               step_q;
	logic [31:0]               mux_q;
	logic [31:0]               step_eff;
	logic [31:0]               end_force;
	logic                      en_q;
	logic [asc_pkg::IRQ_W-1:0] mask_q;
	logic [asc_pkg::IRQ_W-1:0] status;
	logic [asc_pkg::IRQ_W-1:0] set_ev;
	logic [31:0]               rdata_q;
	logic                      wr_step;
	logic                      wr_mux;
	logic                      wr_ctrl;
	logic                      wr_mask;
	logic                      wr_clr;
	logic                      start;

	assign wr_step = wr_i && (addr_i == asc_pkg::OFS_STEP);
	assign wr_mux  = wr_i && (addr_i == asc_pkg::OFS_MUX);
	assign wr_ctrl = wr_i && (addr_i == asc_pkg::OFS_CTRL);
	assign wr_mask = wr_i && (addr_i == asc_pkg::OFS_MASK);
	assign wr_clr  = wr_i && (addr_i == asc_pkg::OFS_CLR);

	// one-slot sequencer: first end marker tied high
	generate
		if (NUM_SLOTS == 1)
		begin : g_force
			assign end_force = 32'h1 << asc_pkg::F_END;
		end
		else
		begin : g_free
			assign end_force = '0;
		end
	endgenerate

	assign step_eff = step_q | end_force;

	// step control word, full 32 bits read/write
	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			step_q <= asc_pkg::STEP_RST;
		else if (wr_step)
			step_q <= wdata_i;
	end

	// input select companion, reserved bits stay zero
	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			mux_q <= asc_pkg::MUX_RST;
		else if (wr_mux)
			mux_q <= wdata_i & asc_pkg::MUX_MASK;
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			en_q <= 1'b0;
		else if (wr_ctrl)
			en_q <= wdata_i[asc_pkg::CTRL_EN];
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			mask_q <= asc_pkg::IRQ_RST;
		else if (wr_mask)
			mask_q <= wdata_i[asc_pkg::IRQ_W-1:0];
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer

	asc_pkg::asc_state_t state_q;
	logic [SW-1:0]       slot_q;
	logic [FW-1:0]       cur;
	logic                last_slot;
	logic                done_ev;
	logic                launch;
	logic [SW-1:0]       launch_slot;
	logic [FW-1:0]       nxt;
	logic [asc_pkg::MUX_W-1:0] nxt_mux;

	assign start     = wr_ctrl && wdata_i[asc_pkg::CTRL_START] && wdata_i[asc_pkg::CTRL_EN]
		&& (state_q == asc_pkg::ASC_IDLE);
	assign cur       = slot_bits(step_eff, slot_q);
	assign done_ev   = (state_q == asc_pkg::ASC_WAIT) && conv_done_i;
	// first end marker stops the walk, later slots are never reached
	assign last_slot = cur[asc_pkg::F_END] || (slot_q == LAST);
	assign launch    = start || (done_ev && !last_slot);
	assign launch_slot = start ? '0 : SW'(slot_q + 1'b1);
	assign nxt       = slot_bits(step_eff, launch_slot);
	assign nxt_mux   = slot_mux(mux_q, launch_slot);

	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			state_q <= asc_pkg::ASC_IDLE;
		else
		begin
			unique case (state_q)
				asc_pkg::ASC_IDLE:
					if (start)
						state_q <= asc_pkg::ASC_REQ;
				asc_pkg::ASC_REQ:
					state_q <= asc_pkg::ASC_WAIT;
				asc_pkg::ASC_WAIT:
					if (done_ev)
						state_q <= last_slot ? asc_pkg::ASC_IDLE : asc_pkg::ASC_REQ;
				default:
					state_q <= asc_pkg::ASC_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			slot_q <= '0;
		else if (launch)
			slot_q <= launch_slot;
	end

	// selection presented to the converter for the launched slot
	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			conv_temp_o <= 1'b0;
			conv_diff_o <= 1'b0;
			conv_pos_o  <= '0;
			conv_neg_o  <= '0;
		end
		else if (launch)
		begin
			conv_temp_o <= nxt[asc_pkg::F_TEMP];
			conv_diff_o <= nxt[asc_pkg::F_DIFF] && !nxt[asc_pkg::F_TEMP];
			if (nxt[asc_pkg::F_TEMP])
			begin
				conv_pos_o <= '0;
				conv_neg_o <= '0;
			end
			else if (nxt[asc_pkg::F_DIFF])
			begin
				conv_pos_o <= {nxt_mux, 1'b0};
				conv_neg_o <= {nxt_mux, 1'b1};
			end
			else
			begin
				conv_pos_o <= {1'b0, nxt_mux};
				conv_neg_o <= '0;
			end
		end
	end

	assign conv_req_o = (state_q == asc_pkg::ASC_REQ);
	assign busy_o     = (state_q != asc_pkg::ASC_IDLE);

	////////////////////////////////////////////////////////////////////////////
	// events and interrupt

	always_comb
	begin
		set_ev = '0;
		set_ev[asc_pkg::ST_RAW]   = done_ev && cur[asc_pkg::F_IRQ];
		set_ev[asc_pkg::ST_DONE]  = done_ev && last_slot;
		set_ev[asc_pkg::ST_NOEND] = done_ev && (slot_q == LAST) && !cur[asc_pkg::F_END];
	end

	asc_irq_stat #(
		.W (asc_pkg::IRQ_W)
	) u_irq (
		.core_clk_i (core_clk_i),
		.rst_b_i    (rst_b_i),
		.set_i      (set_ev),
		.clr_we_i   (wr_clr),
		.clr_i      (wdata_i[asc_pkg::IRQ_W-1:0]),
		.en_i       (mask_q),
		.status_o   (status),
		.irq_o      (irq_o)
	);

	////////////////////////////////////////////////////////////////////////////
	// read port

	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			rdata_q <= '0;
		else if (!rd_i)
			rdata_q <= '0;
		else
		begin
			unique case (addr_i)
				asc_pkg::OFS_CTRL:
					rdata_q <= 32'(en_q) | (32'(busy_o) << asc_pkg::CTRL_BUSY);
				asc_pkg::OFS_RAW:
					rdata_q <= 32'(status);
				asc_pkg::OFS_MASK:
					rdata_q <= 32'(mask_q);
				asc_pkg::OFS_MUX:
					rdata_q <= mux_q;
				asc_pkg::OFS_STEP:
					rdata_q <= step_eff;
				default:
					rdata_q <= '0;
			endcase
		end
	end

	assign rdata_o = rdata_q;

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	a_raw_irq_set: assert property (
		done_ev && cur[asc_pkg::F_IRQ] |=> status[asc_pkg::ST_RAW])
		else $error("raw flag not set after interrupting slot");

	a_raw_irq_quiet: assert property (
		$rose(status[asc_pkg::ST_RAW]) |-> $past(done_ev) && $past(cur[asc_pkg::F_IRQ]))
		else $error("raw flag rose without an interrupting slot");

	a_irq_masking: assert property (
		irq_o |-> |(status & mask_q))
		else $error("interrupt raised while masked");

	a_irq_forward: assert property (
		status[asc_pkg::ST_RAW] && mask_q[asc_pkg::ST_RAW] |-> irq_o)
		else $error("enabled raw flag not forwarded");

	a_end_stops: assert property (
		done_ev && cur[asc_pkg::F_END] |=> state_q == asc_pkg::ASC_IDLE ##1 !conv_req_o)
		else $error("sequence continued past end marker");

	a_slot_advance: assert property (
		done_ev && !last_slot |=> conv_req_o && slot_q == $past(slot_q) + 1'b1)
		else $error("next slot not requested");

	a_no_late_req: assert property (
		conv_req_o && slot_q != '0 |-> !$past(cur[asc_pkg::F_END]))
		else $error("slot after end marker requested");

	a_temp_select: assert property (
		conv_req_o |-> conv_temp_o == $past(nxt[asc_pkg::F_TEMP]) || $past(wr_step))
		else $error("temperature select mismatch");

	a_slot_six: assert property (
		conv_req_o && slot_q == SW'(asc_pkg::SLOT_SIX) && !$past(wr_step)
		&& NUM_SLOTS > asc_pkg::SLOT_SIX
		|-> conv_temp_o == step_eff[asc_pkg::SIX_TEMP])
		else $error("slot six nibble mismatch");

	a_diff_pair: assert property (
		conv_req_o && conv_diff_o |-> conv_neg_o == conv_pos_o + 1'b1 && !conv_pos_o[0])
		else $error("differential pair legs wrong");

	a_single_end: assert property (
		NUM_SLOTS == 1 |-> step_eff[asc_pkg::F_END])
		else $error("single-slot end marker not forced");

	a_read_step: assert property (
		rd_i && addr_i == asc_pkg::OFS_STEP |=> rdata_o == $past(step_eff))
		else $error("step word readback wrong");

	a_step_write: assert property (
		wr_step |=> step_q == $past(wdata_i))
		else $error("step word write lost");

	a_temp_override: assert property (
		conv_req_o && conv_temp_o |-> !conv_diff_o && conv_pos_o == '0 && conv_neg_o == '0)
		else $error("temperature slot drove input selects");

	a_single_legs: assert property (
		conv_req_o && !conv_temp_o && !conv_diff_o
		|-> conv_neg_o == '0 && !conv_pos_o[asc_pkg::CH_W-1])
		else $error("single-ended slot selects wrong");

	a_mux_reserved: assert property (
		(mux_q & ~asc_pkg::MUX_MASK) == '0)
		else $error("input select reserved bit set");

	a_raw_irq_hold: assert property (
		done_ev && !cur[asc_pkg::F_IRQ] && !status[asc_pkg::ST_RAW] |=> !status[asc_pkg::ST_RAW])
		else $error("raw flag set by quiet slot");

endmodule

// ### asc_conv_model.sv
// behavioural converter answering each request after a set delay
`timescale 1ns/1ps
module asc_conv_model (
	input  wire logic       core_clk_i,  // system clock
	input  wire logic       rst_b_i,     // async reset, active low
	input  wire logic       conv_req_i,  // conversion request pulse
	input  wire logic [2:0] dly_i,       // extra wait cycles
	output logic            conv_done_o  // conversion finished pulse
);
	logic [2:0] cnt_q;
	logic       pend_q;

	////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			cnt_q       <= 3'h0;
			pend_q      <= 1'b0;
			conv_done_o <= 1'b0;
		end
		else
		begin
			conv_done_o <= 1'b0;
			if (conv_req_i)
			begin
				cnt_q  <= dly_i;
				pend_q <= 1'b1;
			end
			else if (pend_q && cnt_q == 3'h0)
			begin
				conv_done_o <= 1'b1;
				pend_q      <= 1'b0;
			end
			else if (pend_q)
				cnt_q <= cnt_q - 3'h1;
		end
	end
endmodule

// ### test_asc_step_ctrl.sv
// self-checking bench for the sample step control block
`timescale 1ns/1ps
module test_asc_step_ctrl;
	logic        core_clk_i, rst_b_i, wr_i, rd_i, rd_d, conv_done_i;
	logic        conv_req_o, conv_temp_o, conv_diff_o, busy_o, irq_o;
	logic [11:0] addr_i, addr_d;
	logic [31:0] wdata_i, rdata_o, rdata1;
	logic [3:0]  conv_pos_o, conv_neg_o;
	logic [2:0]  dly;
	logic [31:0] rd_q[$];
	logic [9:0]  req_q[$];
	int          fails, checks;

	asc_step_ctrl dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.conv_req_o(conv_req_o), .conv_temp_o(conv_temp_o), .conv_diff_o(conv_diff_o),
		.conv_pos_o(conv_pos_o), .conv_neg_o(conv_neg_o), .conv_done_i(conv_done_i),
		.busy_o(busy_o), .irq_o(irq_o));
	asc_step_ctrl #(.NUM_SLOTS(1)) dut1 (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata1),
		.conv_req_o(), .conv_temp_o(), .conv_diff_o(), .conv_pos_o(), .conv_neg_o(),
		.conv_done_i(1'b0), .busy_o(), .irq_o());
	asc_conv_model conv (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
		.conv_req_i(conv_req_o), .dly_i(dly), .conv_done_o(conv_done_i));

	////////////////////////////////////////////////////////////////
	initial
	begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic finish_test;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
		@(posedge core_clk_i);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		rd_q.push_back(exp);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		@(posedge core_clk_i);
	endtask

	////////////////////////////////////////////////////////////////
	// watcher: read data in the cycle after the strobe, selects with each request
	always @(posedge core_clk_i)
	begin
		rd_d   <= rd_i;
		addr_d <= addr_i;
	end

	always @(negedge core_clk_i)
	begin
		if (rd_d && rd_q.size() == 0)
			chk(1, 0, "unexpected read");
		else if (rd_d)
			chk(rdata_o, rd_q.pop_front(), "read data");
		if (rd_d && addr_d == asc_pkg::OFS_STEP)
			chk(rdata1[asc_pkg::F_END], 1, "one-slot end marker");
		if (conv_req_o === 1'b1 && req_q.size() == 0)
			chk(1, 0, "request past end marker");
		else if (conv_req_o === 1'b1)
			chk({conv_temp_o, conv_diff_o, conv_pos_o, conv_neg_o}, req_q.pop_front(),
				"slot selects");
	end

	////////////////////////////////////////////////////////////////
	task automatic run(input logic [31:0] step, input logic [31:0] mux);
		logic [3:0] nib;
		logic [2:0] sel;
		logic [2:0] st;
		int         n;
		st = 3'h6;
		for (int k = 0; k < 8; k++)
		begin
			nib = step[4*k+:4];
			sel = mux[4*k+:3];
			if (nib[asc_pkg::F_TEMP])
				req_q.push_back({2'b10, 8'h00});
			else if (nib[asc_pkg::F_DIFF])
				req_q.push_back({2'b01, sel, 1'b0, sel, 1'b1});
			else
				req_q.push_back({2'b00, 1'b0, sel, 4'h0});
			if (nib[asc_pkg::F_IRQ])
				st[0] = 1'b1;
			if (nib[asc_pkg::F_END])
			begin
				st[2] = 1'b0;
				break;
			end
		end
		dly <= 3'($urandom_range(0, 4));
		wr(asc_pkg::OFS_STEP, step);
		wr(asc_pkg::OFS_MUX, mux);
		wr(asc_pkg::OFS_CLR, 32'h0000_0007);
		wr(asc_pkg::OFS_CTRL, 32'h0000_0003);
		n = 0;
		while (busy_o !== 1'b0 && n < 400)
		begin
			@(posedge core_clk_i);
			#1;
			n++;
		end
		@(posedge core_clk_i);
		if (n >= 400 || req_q.size() != 0)
		begin
			chk(1, 0, "sequence did not finish");
			if (n >= 400)
				finish_test();
		end
		rd(asc_pkg::OFS_CTRL, 32'h0000_0001);
		rd(asc_pkg::OFS_RAW, {29'h0, st});
		wr(asc_pkg::OFS_MASK, 32'h0000_0001);
		chk(irq_o, st[0], "masked-in interrupt");
		wr(asc_pkg::OFS_MASK, 32'h0000_0000);
		chk(irq_o, 0, "masked-out interrupt");
		wr(asc_pkg::OFS_CLR, 32'h0000_0007);
		rd(asc_pkg::OFS_RAW, 32'h0000_0000);
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin : main
		logic [31:0] d;
		fails = 0;
		checks = 0;
		rst_b_i = 1'b0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		addr_i = 12'h000;
		wdata_i = 32'h0000_0000;
		dly = 3'h0;
		void'($urandom(32'hea718140));
		repeat (3) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		@(posedge core_clk_i);
		rd(asc_pkg::OFS_STEP, asc_pkg::STEP_RST);
		rd(asc_pkg::OFS_MUX, asc_pkg::MUX_RST);
		rd(asc_pkg::OFS_RAW, 32'h0000_0000);
		rd(12'h0ff, 32'h0000_0000);
		d = $urandom;
		wr(asc_pkg::OFS_STEP, d);
		rd(asc_pkg::OFS_STEP, d);
		wr(asc_pkg::OFS_MUX, d);
		rd(asc_pkg::OFS_MUX, d & asc_pkg::MUX_MASK);
		for (int k = 0; k < 8; k++)
		begin
			d = $urandom & ~32'h2222_2222;
			d[4*k+asc_pkg::F_END] = 1'b1;
			run(d | 32'h2222_2220 << (4*k), $urandom);
		end
		run($urandom & 32'h9999_9999, $urandom);
		if (rd_q.size() != 0 || req_q.size() != 0)
			chk(1, 0, "unanswered requests");
		finish_test();
	end
endmodule
